// ### hw/csc_consts.svh
// offsets, field positions and reset values of the command source combiner
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

// register index map (byte address = index * 4 not used: plain port, word index)
`define CSC_ADDR_W        4
`define CSC_REG_COAST_SEL 4'h0
`define CSC_REG_QSTOP_SEL 4'h1
`define CSC_REG_DCINJ_SEL 4'h2
`define CSC_REG_START_SEL 4'h3
`define CSC_REG_REV_SEL   4'h4
`define CSC_REG_CTRL_WORD 4'h5
`define CSC_REG_STATUS    4'h6

// serial control word bit positions
`define CSC_CW_DCINJ_BIT  2
`define CSC_CW_COAST_BIT  3
`define CSC_CW_QSTOP_BIT  4
`define CSC_CW_START_BIT  6

// selector reset value: or combining
`define CSC_SEL_RESET     2'h3

// control word reset: stop requests inactive, start bit clear
`define CSC_CW_RESET      16'hFFBF

// status register field positions
`define CSC_ST_RUN_COAST  0
`define CSC_ST_RUN_QSTOP  1
`define CSC_ST_RUN_DCINJ  2
`define CSC_ST_START      3

`endif

// ### hw/csc_pkg.sv
// types of the command source combiner
package csc_pkg;
  // selector codes, in order 0..3
  typedef enum logic [1:0] {
    CSC_SRC_DIGITAL,
    CSC_SRC_SERIAL,
    CSC_SRC_AND,
    CSC_SRC_OR
  } csc_src_t;
endpackage

// ### hw/csc_combiner.sv
// command source combiner: digital terminals and serial control word into motor commands
`timescale 1ns/1ps
`include "csc_consts.svh"

module csc_combiner (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [`CSC_ADDR_W-1:0] addr,
  input  wire logic [15:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [15:0]            rdata,
  input  wire logic                   coast_n_pin,
  input  wire logic                   qstop_n_pin,
  input  wire logic                   dcinj_n_pin,
  input  wire logic                   start_pin,
  output logic                        run_coast,
  output logic                        run_qstop,
  output logic                        run_dcinj,
  output logic                        start_cmd,
  output csc_pkg::csc_src_t           reversing_source_select
);
  import csc_pkg::*;

  // selectors and serial control word
  csc_src_t    coast_sel_r;
  csc_src_t    qstop_sel_r;
  csc_src_t    dc_injection_source_select_r;
  csc_src_t    start_sel_r;
  csc_src_t    rev_sel_r;
  logic [15:0] ctrl_word_r;
  logic [15:0] rdata_r;

  // pin synchronisers, three stages each; bit order coast, qstop, dcinj, start
  logic [3:0]  pin_s1_r;
  logic [3:0]  pin_s2_r;
  logic [3:0]  pin_s3_r;
  logic [3:0]  pin_q_r;
  wire  [3:0]  pin_raw = {start_pin, dcinj_n_pin, qstop_n_pin, coast_n_pin};
  logic [3:0]  pin_agree;

  // per-pin agreement of stages two and three; a one-cycle glitch never lands
  for (genvar g = 0; g < 4; g++)
  begin : g_agree
    assign pin_agree[g] = (pin_s2_r[g] == pin_s3_r[g]);
  end
  wire  [3:0]  pin_q_nxt = (pin_q_r & ~pin_agree) | (pin_s3_r & pin_agree);

  // combined commands
  logic run_coast_r;
  logic run_qstop_r;
  logic run_dcinj_r;
  logic start_r;

  // run-permit combine: an inactive (high) level on either source runs under code 2
  function automatic logic permit_combine(input csc_src_t sel, input logic dig,
                                          input logic ser);
    logic res;
    res = 1'b0;
    unique case (sel)
      CSC_SRC_DIGITAL: res = dig;
      CSC_SRC_SERIAL:  res = ser;
      CSC_SRC_AND:     res = dig | ser;
      CSC_SRC_OR:      res = dig & ser;
    endcase
    return res;
  endfunction

  // start combine: direct sense, code 2 needs both
  function automatic logic start_combine(input csc_src_t sel, input logic dig,
                                         input logic ser);
    logic res;
    res = 1'b0;
    unique case (sel)
      CSC_SRC_DIGITAL: res = dig;
      CSC_SRC_SERIAL:  res = ser;
      CSC_SRC_AND:     res = dig & ser;
      CSC_SRC_OR:      res = dig | ser;
    endcase
    return res;
  endfunction

  // address match, shared by the write decode and the read mux
  function automatic logic addr_hit(input logic [`CSC_ADDR_W-1:0] a,
                                    input logic [`CSC_ADDR_W-1:0] idx);
    return a == idx;
  endfunction

  // decoded bus strobes
  wire wr_coast = wr && addr_hit(addr, `CSC_REG_COAST_SEL);
  wire wr_qstop = wr && addr_hit(addr, `CSC_REG_QSTOP_SEL);
  wire wr_dcinj = wr && addr_hit(addr, `CSC_REG_DCINJ_SEL);
  wire wr_start = wr && addr_hit(addr, `CSC_REG_START_SEL);
  wire wr_rev   = wr && addr_hit(addr, `CSC_REG_REV_SEL);
  wire wr_cw    = wr && addr_hit(addr, `CSC_REG_CTRL_WORD);

  // serial bits: low means request for coast, quick-stop, dc braking
  // start bit is active high, unlike the three stop requests
  wire ser_coast = ctrl_word_r[`CSC_CW_COAST_BIT];
  wire ser_qstop = ctrl_word_r[`CSC_CW_QSTOP_BIT];
  wire ser_dcinj = ctrl_word_r[`CSC_CW_DCINJ_BIT];
  wire ser_start = ctrl_word_r[`CSC_CW_START_BIT];

  // next values of the combined commands
  wire coast_nxt = permit_combine(coast_sel_r, pin_q_r[0], ser_coast);
  wire qstop_nxt = permit_combine(qstop_sel_r, pin_q_r[1], ser_qstop);
  wire dcinj_nxt = permit_combine(dc_injection_source_select_r, pin_q_r[2], ser_dcinj);
  wire start_nxt = start_combine(start_sel_r, pin_q_r[3], ser_start);

  // read data mux; unmapped addresses read zero
  wire [15:0] status_w = {12'h000, start_r, run_dcinj_r, run_qstop_r, run_coast_r};
  wire [15:0] rdata_nxt =
    addr_hit(addr, `CSC_REG_COAST_SEL) ? {14'h0, coast_sel_r} :
    addr_hit(addr, `CSC_REG_QSTOP_SEL) ? {14'h0, qstop_sel_r} :
    addr_hit(addr, `CSC_REG_DCINJ_SEL) ? {14'h0, dc_injection_source_select_r} :
    addr_hit(addr, `CSC_REG_START_SEL) ? {14'h0, start_sel_r} :
    addr_hit(addr, `CSC_REG_REV_SEL)   ? {14'h0, rev_sel_r} :
    addr_hit(addr, `CSC_REG_CTRL_WORD) ? ctrl_word_r :
    addr_hit(addr, `CSC_REG_STATUS)    ? status_w : 16'h0000;

  // selector registers; only the low two bits of a write matter
  // two bits carry all four codes, so no illegal selector value can arise
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      coast_sel_r                  <= csc_src_t'(`CSC_SEL_RESET);
      qstop_sel_r                  <= csc_src_t'(`CSC_SEL_RESET);
      dc_injection_source_select_r <= csc_src_t'(`CSC_SEL_RESET);
      start_sel_r                  <= csc_src_t'(`CSC_SEL_RESET);
      rev_sel_r                    <= csc_src_t'(`CSC_SEL_RESET);
    end
    else
    begin
      if (wr_coast) coast_sel_r <= csc_src_t'(wdata[1:0]);
      if (wr_qstop) qstop_sel_r <= csc_src_t'(wdata[1:0]);
      if (wr_dcinj) dc_injection_source_select_r <= csc_src_t'(wdata[1:0]);
      if (wr_start) start_sel_r <= csc_src_t'(wdata[1:0]);
      if (wr_rev)   rev_sel_r   <= csc_src_t'(wdata[1:0]);
    end
  end

  // control word resets to FFBF, all ones but the start bit, so no serial stop request stands after reset
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_word_r <= `CSC_CW_RESET;
    else if (wr_cw)
      ctrl_word_r <= wdata;
  end

  // read data valid the cycle after the read strobe only
  // zero outside that cycle, so stale data never lingers on the port
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_r <= 16'h0000;
    else if (rd)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= 16'h0000;
  end

  // three-stage pin sync; level moves on once stages two and three agree
  // stages reset low, so stop requests stand until the idle levels land
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      pin_s3_r <= 4'h0;
      pin_q_r  <= 4'h0;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_q_r  <= pin_q_nxt;
    end
  end

  // commands recomputed every cycle; reset shows stop on all
  // one cycle of latency buys outputs free of combine glitches
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      run_coast_r <= 1'b0;
      run_qstop_r <= 1'b0;
      run_dcinj_r <= 1'b0;
      start_r     <= 1'b0;
    end
    else
    begin
      run_coast_r <= coast_nxt;
      run_qstop_r <= qstop_nxt;
      run_dcinj_r <= dcinj_nxt;
      start_r     <= start_nxt;
    end
  end

  // every output straight from its flip-flop
  assign rdata                   = rdata_r;
  assign run_coast               = run_coast_r;
  assign run_qstop               = run_qstop_r;
  assign run_dcinj               = run_dcinj_r;
  assign start_cmd               = start_r;
  assign reversing_source_select = rev_sel_r;
endmodule

// ### verif/csc_terminal_model.sv
// input terminal model: the four contacts seen by the combiner
`timescale 1ns/1ps
module csc_terminal_model (
  input  wire logic       clock,
  input  wire logic [3:0] level,
  output logic            coast_n_pin,
  output logic            qstop_n_pin,
  output logic            dcinj_n_pin,
  output logic            start_pin
);
  // contacts move just after an edge; all idle (no request) at power up
  initial {start_pin, dcinj_n_pin, qstop_n_pin, coast_n_pin} = 4'h7;
  always @(posedge clock)
  begin
    coast_n_pin <= level[0];
    qstop_n_pin <= level[1];
    dcinj_n_pin <= level[2];
    start_pin   <= level[3];
  end
endmodule

// ### verif/csc_combiner_monitor.sv
// port checker for the command source combiner
`timescale 1ns/1ps
`include "csc_consts.svh"
module csc_combiner_monitor (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic [3:0]        addr,
  input wire logic [15:0]       wdata,
  input wire logic              wr,
  input wire logic              coast_n_pin,
  input wire logic              qstop_n_pin,
  input wire logic              dcinj_n_pin,
  input wire logic              start_pin,
  input wire logic              run_coast,
  input wire logic              run_qstop,
  input wire logic              run_dcinj,
  input wire logic              start_cmd,
  input wire csc_pkg::csc_src_t reversing_source_select
);
  import csc_pkg::*;
  logic [1:0]  sel_r [4];
  logic [15:0] cw_r;
  logic [2:0]  q_r;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  function automatic logic fx(logic [1:0] c, logic d, logic s, logic st);
    fx = c == 2'h0 ? d : c == 2'h1 ? s : (c == 2'h2) ^ st ? d | s : d & s;
  endfunction
  // shadow settings; q_r counts quiet cycles, pins need 5 edges to land
  always_ff @(posedge clock)
  begin
    if (rst) sel_r <= '{default: 2'h3};
    else if (wr && addr < 4'h4) sel_r[addr[1:0]] <= wdata[1:0];
    cw_r <= rst ? `CSC_CW_RESET : (wr && addr == 4'h5) ? wdata : cw_r;
    if (rst || wr || !$stable({coast_n_pin, qstop_n_pin, dcinj_n_pin, start_pin})) q_r <= 3'h0;
    else if (q_r != 3'h7) q_r <= q_r + 3'h1;
  end
  coast_table_a: assert property (q_r == 3'h7 |->
    run_coast == fx(sel_r[0], coast_n_pin, cw_r[3], 1'b0)) else $error("run_coast wrong");
  qstop_table_a: assert property (q_r == 3'h7 |->
    run_qstop == fx(sel_r[1], qstop_n_pin, cw_r[4], 1'b0)) else $error("run_qstop wrong");
  dcinj_table_a: assert property (q_r == 3'h7 |->
    run_dcinj == fx(sel_r[2], dcinj_n_pin, cw_r[2], 1'b0)) else $error("run_dcinj wrong");
  start_table_a: assert property (q_r == 3'h7 |->
    start_cmd == fx(sel_r[3], start_pin, cw_r[6], 1'b1)) else $error("start_cmd wrong");
  reset_sel_a: assert property (disable iff (1'b0) rst |=>
    reversing_source_select == CSC_SRC_OR) else $error("selector reset wrong");
  rev_store_a: assert property (wr && addr == 4'h4 |=>
    reversing_source_select == $past(wdata[1:0])) else $error("reversing selector wrong");
  no_cause_a: assert property (!$stable({run_coast, run_qstop, run_dcinj, start_cmd}) |->
    q_r != 3'h7) else $error("output moved alone");
  serial_bits_a: assert property (wr && addr == 4'h5 && sel_r[0] == 2'h1 &&
    sel_r[1] == 2'h1 && sel_r[2] == 2'h1 |-> ##2 {run_coast, run_qstop, run_dcinj} ==
    {$past(wdata[3], 2), $past(wdata[4], 2), $past(wdata[2], 2)})
    else $error("serial bit wrong");
  cover property (q_r == 3'h7 && !run_coast);
  cover property (q_r == 3'h7 && start_cmd);
  cover property (wr && addr == 4'h4);
endmodule
bind csc_combiner csc_combiner_monitor mon (.*);

// ### verif/tb.sv
// self-checking bench for the command source combiner
`timescale 1ns/1ps
`include "csc_consts.svh"
module tb;
  import csc_pkg::*;
  logic       clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0, lvl = 4'h7;
  logic [15:0] wdata = 16'h0, rdata;
  logic       coast_n_pin, qstop_n_pin, dcinj_n_pin, start_pin;
  logic       run_coast, run_qstop, run_dcinj, start_cmd;
  csc_src_t   reversing_source_select;
  int         mismatches = 0, cmp_count = 0;
  always #20 clock = ~clock;
  csc_combiner DUT (.*);
  csc_terminal_model term (.clock, .level(lvl), .coast_n_pin, .qstop_n_pin,
                           .dcinj_n_pin, .start_pin);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one write, then a gap so wr is never raised in the step it drops
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    @(posedge clock);
  endtask
  task automatic t_reset();
    for (int a = 0; a < 5; a++) rreg(a[3:0], {14'h0, `CSC_SEL_RESET});
    rreg(4'h5, `CSC_CW_RESET);
  endtask
  // every code against every terminal/serial pair, each command distinct
  task automatic t_tables();
    logic [3:0] s, e;
    for (int c = 0; c < 4; c++)
    begin
      for (int k = 0; k < 4; k++) wreg(k[3:0], c[15:0]);
      for (int v = 0; v < 16; v++)
      begin
        s = {v[2:0], v[3]} ^ 4'h5;
        lvl <= v[3:0];
        wreg(4'h5, 16'hFFA3 | {9'h0, s[3], 1'b0, s[1], s[0], s[2], 2'h0});
        repeat (6) @(posedge clock);
        for (int k = 0; k < 4; k++)
          e[k] = c == 0 ? v[k] : c == 1 ? s[k] : (c == 2) ^ (k == 3) ? v[k] | s[k] : v[k] & s[k];
        chk("commands", {12'h0, e}, {12'h0, start_cmd, run_dcinj, run_qstop, run_coast});
        rreg(4'h6, {12'h0, e});
      end
    end
  endtask
  task automatic t_misc();
    for (int c = 0; c < 4; c++)
    begin
      wreg(4'h4, 16'hFFFC | c[15:0]);
      chk("reversing", c[15:0], {14'h0, reversing_source_select});
    end
    wreg(4'h7, 16'hFFFF);
    rreg(4'h7, 16'h0);
    wreg(4'h6, 16'h0000);
    for (int a = 0; a < 5; a++) rreg(a[3:0], 16'h3);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_tables();
    t_misc();
    give_verdict();
  end
endmodule
